// *** logic/ocp_cfg_pkg.sv ***
package ocp_cfg_pkg;

    // -----------------------------------------------------------------
    // bus geometry
    // -----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;

    // register indices; byte address is four times the index
    localparam logic [ADDR_W-1:0] CFG_INDEX = 8'h1E;
    localparam logic [ADDR_W-1:0] AUX_INDEX = 8'h20;
    localparam logic [ADDR_W-1:0] STATUS_INDEX = 8'h21;
    localparam logic [ADDR_W-1:0] CFG_ADDR = CFG_INDEX << 2;
    localparam logic [ADDR_W-1:0] AUX_ADDR = AUX_INDEX << 2;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = STATUS_INDEX << 2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // -----------------------------------------------------------------
    // field layouts
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        AZ_INTERNAL_SYNC = 2'h0,
        AZ_OFF = 2'h1,
        AZ_EXTERNAL_SYNC = 2'h2,
        AZ_EXTERNAL_CP_GATE = 2'h3
    } autozero_t;

    typedef enum logic [1:0] {
        TRIG_COUNT_8 = 2'h0,
        TRIG_COUNT_16 = 2'h1,
        TRIG_EVERY = 2'h2,
        TRIG_NEVER = 2'h3
    } trigger_t;

    typedef struct packed {
        autozero_t autozero_select;
        logic negative_overcurrent_disable;
        logic reserved;
        logic pulse_truncation_disable;
        logic brake_on_overcurrent;
        logic rdson_sensing;
        logic overcurrent_latch_select;
        logic [3:0] negative_overcurrent_threshold;
        logic [3:0] positive_overcurrent_threshold;
    } cfg_t;

    typedef struct packed {
        logic [1:0] sense_timing_mode;
        trigger_t overcurrent_fault_trigger_select;
    } aux_t;

    localparam logic [REG_W-1:0] CFG_RESET = 16'h0833;
    localparam logic [3:0] AUX_RESET = 4'h0;
    localparam int AUX_W = 4;
    localparam logic [1:0] TMODE_GL_ON = 2'h1;

    localparam int STAT_FAULT_BIT = 0;
    localparam int STAT_POS_BIT = 1;
    localparam int STAT_NEG_BIT = 2;
    localparam int STAT_CNT_LSB = 4;

    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] COUNT_8 = 5'h08;
    localparam logic [CNT_W-1:0] COUNT_16 = 5'h10;
    localparam logic [CNT_W-1:0] COUNT_ONE = 5'h01;

    // threshold magnitude in mV per code
    localparam int MV_W = 9;
    localparam logic [MV_W-1:0] THR_MV_TABLE [16] = '{
        9'h12C, 9'h0FA, 9'h0E1, 9'h0C8, 9'h0AF, 9'h096, 9'h07D, 9'h064,
        9'h05A, 9'h050, 9'h046, 9'h03C, 9'h032, 9'h028, 9'h01E, 9'h014
    };

endpackage : ocp_cfg_pkg

// *** logic/threshold_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
module threshold_decode
    import ocp_cfg_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] code,
    output logic [ocp_cfg_pkg::MV_W-1:0] magnitude_mv
);
    logic [MV_W-1:0] magnitude_reg;
    wire logic [MV_W-1:0] magnitude_next = THR_MV_TABLE[code];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            magnitude_reg <= THR_MV_TABLE[CFG_RESET[3:0]];
        else
            magnitude_reg <= magnitude_next;
    end

    assign magnitude_mv = magnitude_reg;
endmodule : threshold_decode
`default_nettype wire

// *** logic/sense_amp_protection_config.sv ***
// Contract
// RULE1 - four-bit negative threshold, code 0 is -300, all-ones is -20
// RULE2 - latch bit 0 leaves fault unlatched, 1 latches it
// RULE3 - mode bit 0 selects shunt sensing, 1 selects on-resistance sensing
// RULE4 - on-resistance sensing forces timing mode to low-side-gate-on only
// RULE5 - brake bit 1 brakes on fault and latches it; 0 no braking
// RULE6 - truncation disable bit stops pwm truncation, fault triggering unchanged
// RULE7 - reserved bit 12 always reads zero
// RULE8 - negative disable bit suppresses negative truncation and fault reporting
// RULE9 - auto-zero field: internal, off, external, external with pump clock gating
// RULE10 - four-bit positive threshold, code 0 is 300 mV, all-ones 20 mV
// RULE11 - register at offset 1E, reset value 0833
// RULE12 - fault trigger after 8, 16, every event, or never
// RULE13 - writes to reserved bit ignored; other fields update on write
`timescale 1ns/1ps
`default_nettype none
module sense_amp_protection_config
    import ocp_cfg_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ocp_cfg_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [ocp_cfg_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ocp_cfg_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [ocp_cfg_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic positive_overcurrent,
    input wire logic negative_overcurrent,
    output logic truncate_pwm,
    output logic overcurrent_fault,
    output logic brake_request,
    output logic rdson_sensing,
    output logic [1:0] effective_timing_mode,
    output logic autozero_enable,
    output logic autozero_external_sync,
    output logic charge_pump_clock_gate,
    output logic [ocp_cfg_pkg::MV_W-1:0] positive_threshold_mv,
    output logic [ocp_cfg_pkg::MV_W-1:0] negative_threshold_mv
);
    import ocp_cfg_pkg::*;

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    cfg_t cfg_reg;
    aux_t aux_reg;
    logic aw_held_reg, w_held_reg, awready_reg, wready_reg, bvalid_reg;
    logic arready_reg, rvalid_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [DATA_W-1:0] wdata_reg, rdata_reg;
    logic [3:0] wstrb_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic pos_prev_reg, neg_prev_reg;
    logic [CNT_W-1:0] count_reg;
    logic fault_reg, truncate_reg, brake_reg, rdson_reg;
    logic [1:0] tmode_reg;
    logic az_en_reg, az_ext_reg, cp_gate_reg;

    // -----------------------------------------------------------------
    // write channel
    // -----------------------------------------------------------------
    wire logic aw_take = awvalid & awready_reg;
    wire logic w_take = wvalid & wready_reg;
    wire logic do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
    wire logic b_done = bvalid_reg & bready;
    wire logic aw_held_next = (aw_held_reg | aw_take) & ~do_write;
    wire logic w_held_next = (w_held_reg | w_take) & ~do_write;
    wire logic bvalid_next = (bvalid_reg & ~bready) | do_write;
    wire logic wr_cfg = do_write & (awaddr_reg == CFG_ADDR);
    wire logic wr_aux = do_write & (awaddr_reg == AUX_ADDR);
    wire logic wr_stat = do_write & (awaddr_reg == STATUS_ADDR);
    wire logic wr_hit = wr_cfg | wr_aux | wr_stat;

    // byte lanes, reserved bit kept at zero
    wire logic [REG_W-1:0] cfg_bits = cfg_reg;
    wire logic [REG_W-1:0] cfg_merged = {
        wstrb_reg[1] ? wdata_reg[15:8] : cfg_bits[15:8],
        wstrb_reg[0] ? wdata_reg[7:0] : cfg_bits[7:0]};
    wire cfg_t cfg_written = cfg_t'(cfg_merged);
    cfg_t cfg_next;
    always_comb
    begin
        cfg_next = cfg_reg;
        if (wr_cfg)
        begin
            cfg_next = cfg_written;                            // [RULE13]
        end
        cfg_next.reserved = 1'b0;                              // [RULE7] [RULE13]
    end
    wire aux_t aux_next = (wr_aux & wstrb_reg[0]) ? aux_t'(wdata_reg[AUX_W-1:0]) : aux_reg;
    wire logic clear_fault = wr_stat & wstrb_reg[0] & wdata_reg[STAT_FAULT_BIT];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
        end
        else
        begin
            aw_held_reg <= aw_held_next;
            w_held_reg <= w_held_next;
            awready_reg <= ~aw_held_next & ~bvalid_next;
            wready_reg <= ~w_held_next & ~bvalid_next;
            bvalid_reg <= bvalid_next;
            if (do_write)
                bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            if (aw_take)
                awaddr_reg <= awaddr;
            if (w_take)
            begin
                wdata_reg <= wdata;
                wstrb_reg <= wstrb;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cfg_reg <= cfg_t'(CFG_RESET);                      // [RULE11]
            aux_reg <= aux_t'(AUX_RESET);
        end
        else
        begin
            cfg_reg <= cfg_next;
            aux_reg <= aux_next;
        end
    end

    // -----------------------------------------------------------------
    // read channel
    // -----------------------------------------------------------------
    wire logic ar_take = arvalid & arready_reg;
    wire logic rvalid_next = (rvalid_reg & ~rready) | ar_take;
    wire logic [DATA_W-1:0] stat_word = {{(DATA_W-STAT_CNT_LSB-CNT_W){1'b0}}, count_reg,
        1'b0, neg_prev_reg & ~cfg_reg.negative_overcurrent_disable, pos_prev_reg, fault_reg};
    wire logic rd_cfg = araddr == CFG_ADDR;
    wire logic rd_aux = araddr == AUX_ADDR;
    wire logic rd_stat = araddr == STATUS_ADDR;
    wire logic [DATA_W-1:0] rd_word =
        rd_cfg ? {{(DATA_W-REG_W){1'b0}}, cfg_bits} :         // [RULE7]
        rd_aux ? {{(DATA_W-AUX_W){1'b0}}, aux_reg} :
        rd_stat ? stat_word : '0;
    wire logic [1:0] rd_resp = (rd_cfg | rd_aux | rd_stat) ? RESP_OKAY : RESP_SLVERR;
    wire cfg_t rd_cfg_view = cfg_t'(rdata_reg[REG_W-1:0]);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end
        else
        begin
            arready_reg <= ~rvalid_next;
            rvalid_reg <= rvalid_next;
            if (ar_take)
            begin
                rdata_reg <= rd_word;
                rresp_reg <= rd_resp;
            end
        end
    end

    // -----------------------------------------------------------------
    // protection logic
    // -----------------------------------------------------------------
    // negative comparator is masked before edge detection, so a disabled
    // negative trip never counts, truncates or reports
    wire logic neg_live = negative_overcurrent & ~cfg_reg.negative_overcurrent_disable; // [RULE8]
    wire logic oc_level = positive_overcurrent | neg_live;
    wire logic oc_event = (positive_overcurrent & ~pos_prev_reg) |
        (neg_live & ~neg_prev_reg);
    wire logic fault_latched = cfg_reg.overcurrent_latch_select |    // [RULE2]
        cfg_reg.brake_on_overcurrent;                                // [RULE5]
    logic [CNT_W-1:0] count_target;
    always_comb
    begin
        case (aux_reg.overcurrent_fault_trigger_select)                // [RULE12]
            TRIG_COUNT_8: count_target = COUNT_8;
            TRIG_COUNT_16: count_target = COUNT_16;
            TRIG_EVERY: count_target = COUNT_ONE;
            default: count_target = '0;
        endcase
    end
    wire logic trig_never = aux_reg.overcurrent_fault_trigger_select == TRIG_NEVER;
    wire logic [CNT_W-1:0] count_inc = CNT_W'(count_reg + COUNT_ONE);
    // a count left over from a longer trigger setting trips on the next event if it is already at or past the new target minus one
    wire logic fault_set = oc_event & ~trig_never & (count_inc >= count_target); // [RULE12]
    // unlatched faults drop once the comparators are quiet; a new event wins
    wire logic fault_drop = fault_latched ? clear_fault : (~oc_level | clear_fault); // [RULE2]
    wire logic fault_next = fault_set | (fault_reg & ~fault_drop);
    wire logic [CNT_W-1:0] count_next = (fault_set | clear_fault | trig_never) ? '0 :
        oc_event ? count_inc : count_reg;
    // truncation ignores the trigger setting, even in the never case
    wire logic truncate_next = oc_level & ~cfg_reg.pulse_truncation_disable; // [RULE6] [RULE8]
    wire logic brake_next = fault_next & cfg_reg.brake_on_overcurrent;      // [RULE5]
    wire logic [1:0] tmode_next = cfg_reg.rdson_sensing ? TMODE_GL_ON :     // [RULE4]
        aux_reg.sense_timing_mode;
    wire autozero_t az_sel = cfg_reg.autozero_select;
    wire logic az_en_next = az_sel != AZ_OFF;                               // [RULE9]
    wire logic az_ext_next = (az_sel == AZ_EXTERNAL_SYNC) | (az_sel == AZ_EXTERNAL_CP_GATE);
    wire logic cp_gate_next = az_sel == AZ_EXTERNAL_CP_GATE;                // [RULE9]

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pos_prev_reg <= 1'b0;
            neg_prev_reg <= 1'b0;
            count_reg <= '0;
            fault_reg <= 1'b0;
            truncate_reg <= 1'b0;
            brake_reg <= 1'b0;
            rdson_reg <= 1'b0;
            tmode_reg <= '0;
            az_en_reg <= 1'b1;
            az_ext_reg <= 1'b0;
            cp_gate_reg <= 1'b0;
        end
        else
        begin
            pos_prev_reg <= positive_overcurrent;
            neg_prev_reg <= neg_live;
            count_reg <= count_next;
            fault_reg <= fault_next;
            truncate_reg <= truncate_next;
            brake_reg <= brake_next;
            rdson_reg <= cfg_reg.rdson_sensing;                 // [RULE3]
            tmode_reg <= tmode_next;
            az_en_reg <= az_en_next;
            az_ext_reg <= az_ext_next;
            cp_gate_reg <= cp_gate_next;
        end
    end

    // -----------------------------------------------------------------
    // threshold decoders
    // -----------------------------------------------------------------
    threshold_decode pos_decode (                               // [RULE10]
        .aclk(aclk),
        .aresetn(aresetn),
        .code(cfg_reg.positive_overcurrent_threshold),
        .magnitude_mv(positive_threshold_mv)
    );
    threshold_decode neg_decode (                               // [RULE1]
        .aclk(aclk),
        .aresetn(aresetn),
        .code(cfg_reg.negative_overcurrent_threshold),
        .magnitude_mv(negative_threshold_mv)
    );

    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
    assign truncate_pwm = truncate_reg;
    assign overcurrent_fault = fault_reg;
    assign brake_request = brake_reg;
    assign rdson_sensing = rdson_reg;
    assign effective_timing_mode = tmode_reg;
    assign autozero_enable = az_en_reg;
    assign autozero_external_sync = az_ext_reg;
    assign charge_pump_clock_gate = cp_gate_reg;

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    neg_thr_map_a: assert property ($stable(cfg_reg) |->          // [RULE1]
        negative_threshold_mv == THR_MV_TABLE[cfg_reg.negative_overcurrent_threshold])
        else $error("negative threshold magnitude wrong");
    latch_hold_a: assert property (fault_reg & fault_latched & ~clear_fault |=> // [RULE2]
        fault_reg) else $error("latched fault dropped");
    unlatch_drop_a: assert property (fault_reg & ~fault_latched & ~oc_level & ~oc_event |=> // [RULE2]
        ~fault_reg) else $error("unlatched fault stuck");
    rdson_out_a: assert property (##1 cfg_reg.rdson_sensing |=> rdson_sensing) // [RULE3]
        else $error("sensing mode not driven");
    tmode_force_a: assert property (cfg_reg.rdson_sensing |=>               // [RULE4]
        effective_timing_mode == TMODE_GL_ON) else $error("timing mode not forced");
    brake_fault_a: assert property (brake_request |-> overcurrent_fault &&  // [RULE5]
        $past(cfg_reg.brake_on_overcurrent)) else $error("brake without fault");
    trunc_dis_a: assert property (cfg_reg.pulse_truncation_disable |=>      // [RULE6]
        ~truncate_pwm) else $error("truncation while disabled");
    trunc_on_a: assert property (positive_overcurrent & ~cfg_reg.pulse_truncation_disable |=> // [RULE6]
        truncate_pwm) else $error("missing truncation");
    res_read_a: assert property (ar_take & rd_cfg |=> ~rd_cfg_view.reserved) // [RULE7]
        else $error("reserved bit read as one");
    neg_mask_a: assert property (cfg_reg.negative_overcurrent_disable & ~positive_overcurrent |=> // [RULE8]
        ~truncate_pwm) else $error("negative trip not masked");
    az_decode_a: assert property (##1 $stable(cfg_reg) |=> autozero_enable ==  // [RULE9]
        ($past(cfg_reg.autozero_select) != AZ_OFF)) else $error("auto-zero decode wrong");
    pos_thr_map_a: assert property ($stable(cfg_reg) |->          // [RULE10]
        positive_threshold_mv == THR_MV_TABLE[cfg_reg.positive_overcurrent_threshold])
        else $error("positive threshold magnitude wrong");
    never_trig_a: assert property (trig_never & ~fault_reg |=> ~fault_reg)  // [RULE12]
        else $error("fault raised in never mode");
    every_trig_a: assert property (oc_event & (aux_reg == aux_t'({2'h0, TRIG_EVERY})) |=> // [RULE12]
        fault_reg) else $error("every-event trigger missed");
    write_resp_a: assert property (do_write |=> bvalid) else $error("no write response"); // [RULE13]

    write_cfg_c: cover property (wr_cfg);
    fault_raise_c: cover property (fault_set & ~fault_reg);
    brake_c: cover property (brake_request);
    latched_clear_c: cover property (fault_reg & fault_latched & clear_fault);
endmodule : sense_amp_protection_config
`default_nettype wire

// *** test/sense_amp_protection_config_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module sense_amp_protection_config_tb;
    import ocp_cfg_pkg::*;

    // ------------------------------------------------------------
    // clock, reset, stimulus and response signals
    // ------------------------------------------------------------
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r;
    logic positive_overcurrent, negative_overcurrent;
    logic truncate_pwm, overcurrent_fault, brake_request, rdson_sensing;
    logic autozero_enable, autozero_external_sync, charge_pump_clock_gate;
    logic [1:0] effective_timing_mode;
    logic [MV_W-1:0] positive_threshold_mv, negative_threshold_mv;
    wire logic [2:0] az_out;
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;
    // expected magnitude per threshold code, in mV
    localparam logic [8:0] MV_EXP [16] = '{9'h12C, 9'h0FA, 9'h0E1, 9'h0C8, 9'h0AF, 9'h096,
        9'h07D, 9'h064, 9'h05A, 9'h050, 9'h046, 9'h03C, 9'h032, 9'h028, 9'h01E, 9'h014};

    assign az_out = {autozero_enable, autozero_external_sync, charge_pump_clock_gate};

    always #20 aclk = ~aclk;

    sense_amp_protection_config u_sense_amp_protection_config (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .positive_overcurrent(positive_overcurrent), .negative_overcurrent(negative_overcurrent),
        .truncate_pwm(truncate_pwm), .overcurrent_fault(overcurrent_fault),
        .brake_request(brake_request), .rdson_sensing(rdson_sensing),
        .effective_timing_mode(effective_timing_mode), .autozero_enable(autozero_enable),
        .autozero_external_sync(autozero_external_sync),
        .charge_pump_clock_gate(charge_pump_clock_gate),
        .positive_threshold_mv(positive_threshold_mv),
        .negative_threshold_mv(negative_threshold_mv)
    );

    // ------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------
    task automatic conclude;
    begin
        if (err_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask : conclude

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
    begin
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    end
    endtask : check

    // address and data are offered together and released one by one as taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    begin
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'h3;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end while (awvalid || wvalid);
        while (bvalid !== 1'b1)
            @(posedge aclk);
        resp = bresp;
        bready <= 1'b0;
    end
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    begin
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
            @(posedge aclk);
        while (arready !== 1'b1);
        arvalid <= 1'b0;
        do
            @(posedge aclk);
        while (rvalid !== 1'b1);
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
    end
    endtask : axi_read

    // outputs follow the register one cycle later, so settle before any check
    task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
        logic [1:0] resp;
    begin
        axi_write(a, v, resp);
        check(32'(resp), 32'(RESP_OKAY));
        repeat (3) @(posedge aclk);
    end
    endtask : reg_write

    task automatic pulse(input int n);
    begin
        repeat (n)
        begin
            positive_overcurrent <= 1'b1;
            @(posedge aclk);
            positive_overcurrent <= 1'b0;
            repeat (4) @(posedge aclk);
        end
    end
    endtask : pulse

    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'h0;
        positive_overcurrent = 1'b0;
        negative_overcurrent = 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        axi_read(CFG_ADDR, d, r);
        check(d, 32'h0000_0833);
        check(32'(r), 32'(RESP_OKAY));
        check(32'({az_out, positive_threshold_mv}), 32'({3'h4, 9'h0C8}));
        reg_write(CFG_ADDR, 32'hFFFF_FFFF);
        axi_read(CFG_ADDR, d, r);
        check(d, 32'h0000_EFFF);
        axi_write(8'hFC, 32'h0, r);
        check(32'(r), 32'(RESP_SLVERR));
        axi_read(8'hFC, d, r);
        check(d, 32'h0);
        check(32'(r), 32'(RESP_SLVERR));
        axi_read(CFG_ADDR, d, r);
        check(d, 32'h0000_EFFF);
        for (int i = 0; i < 16; i++)
        begin
            reg_write(CFG_ADDR, {16'h0, 8'h08, i[3:0], 4'(15 - i)});
            check(32'(negative_threshold_mv), 32'(MV_EXP[i]));
            check(32'(positive_threshold_mv), 32'(MV_EXP[15 - i]));
        end
        for (int a = 0; a < 4; a++)
        begin
            reg_write(CFG_ADDR, {16'h0, a[1:0], 14'h0033});
            check(32'(az_out), 32'({a != 1, a[1], a == 3}));
        end
        reg_write(AUX_ADDR, 32'h8);
        reg_write(CFG_ADDR, 32'h0033);
        check(32'({rdson_sensing, effective_timing_mode}), 32'h2);
        reg_write(CFG_ADDR, 32'h0233);
        check(32'({rdson_sensing, effective_timing_mode}), 32'h5);
        // never-trigger mode: truncation only, no fault
        reg_write(AUX_ADDR, 32'h3);
        reg_write(CFG_ADDR, 32'h0033);
        positive_overcurrent <= 1'b1;
        repeat (3) @(posedge aclk);
        check(32'({truncate_pwm, overcurrent_fault}), 32'h2);
        reg_write(CFG_ADDR, 32'h0833);
        check(32'(truncate_pwm), 32'h0);
        positive_overcurrent <= 1'b0;
        negative_overcurrent <= 1'b1;
        reg_write(CFG_ADDR, 32'h2033);
        check(32'(truncate_pwm), 32'h0);
        reg_write(CFG_ADDR, 32'h0033);
        check(32'(truncate_pwm), 32'h1);
        negative_overcurrent <= 1'b0;
        reg_write(AUX_ADDR, 32'h2);
        reg_write(CFG_ADDR, 32'h2133);
        negative_overcurrent <= 1'b1;
        repeat (4) @(posedge aclk);
        negative_overcurrent <= 1'b0;
        repeat (4) @(posedge aclk);
        check(32'(overcurrent_fault), 32'h0);
        reg_write(CFG_ADDR, 32'h0033);
        positive_overcurrent <= 1'b1;
        repeat (4) @(posedge aclk);
        check(32'(overcurrent_fault), 32'h1);
        positive_overcurrent <= 1'b0;
        repeat (4) @(posedge aclk);
        check(32'(overcurrent_fault), 32'h0);
        reg_write(CFG_ADDR, 32'h0133);
        pulse(1);
        check(32'({overcurrent_fault, brake_request}), 32'h2);
        reg_write(STATUS_ADDR, 32'h1);
        check(32'(overcurrent_fault), 32'h0);
        reg_write(CFG_ADDR, 32'h0C33);
        positive_overcurrent <= 1'b1;
        repeat (4) @(posedge aclk);
        check(32'(truncate_pwm), 32'h0);
        positive_overcurrent <= 1'b0;
        repeat (4) @(posedge aclk);
        check(32'({overcurrent_fault, brake_request}), 32'h3);
        reg_write(STATUS_ADDR, 32'h1);
        check(32'({overcurrent_fault, brake_request}), 32'h0);
        for (int m = 0; m < 2; m++)
        begin
            reg_write(AUX_ADDR, 32'(m));
            reg_write(CFG_ADDR, 32'h0133);
            pulse(m == 0 ? 7 : 15);
            check(32'(overcurrent_fault), 32'h0);
            pulse(1);
            check(32'(overcurrent_fault), 32'h1);
            reg_write(STATUS_ADDR, 32'h1);
        end
        conclude();
    end

endmodule : sense_amp_protection_config_tb
`default_nettype wire
